//--- hpf_regs.svh
// Functional notes
// - Flow permit high only while host may send
// - Clock pin serial clock; high disables echo
// - Doze input controls sleep; awake output follows
// - UART: first pin follows field code
// - SPI/I2C: first pin gate or noise
// - SPI/I2C: second pin defaults to busy
// - Drive-active output high only while transmitting
// - Command pin; chip select in SPI
// - Serial out data; two-way in I2C
// - 251 channels, 5 MHz base, 100 kHz steps
// - Exactly four bitrate and coding settings
// - Two 1024-byte FIFOs, transmit and receive
// - Transmit bytes pass only in SPI and I2C host protocols
`ifndef HPF_REGS_SVH
`define HPF_REGS_SVH
`define HPF_MODE_UART       2'h0
`define HPF_MODE_DMX        2'h1
`define HPF_MODE_SPI        2'h2
`define HPF_MODE_I2C        2'h3
`define HPF_FUNC_LSB        4
`define HPF_FUNC_MSB        5
`define HPF_FUNC_RST        2'h0
`define HPF_FUNC_ALT        2'h1
`define HPF_FUNC_OUT        2'h2
`define HPF_FUNC_BAD        2'h3
`define HPF_FIFO_DEPTH      1024
`define HPF_FIFO_AW         10
`define HPF_SKID_DEPTH      2
`define HPF_SKID_AW         1
`define HPF_PERMIT_MARGIN   11'h008
`define HPF_CHAN_COUNT      8'hfb
`define HPF_CHAN_BASE_KHZ   15'h1388
`define HPF_CHAN_STEP_KHZ   15'h0064
`define HPF_RATE_1M4        2'h0
`define HPF_RATE_1M0        2'h1
`define HPF_RATE_490K       2'h2
`define HPF_RATE_225K       2'h3
`endif

//--- hpf_pkg.sv
package hpf_pkg;
	// Host protocol as picked by the straps
	typedef enum logic [1:0]
	{
		HPF_UART = 2'h0,
		HPF_DMX  = 2'h1,
		HPF_SPI  = 2'h2,
		HPF_I2C  = 2'h3
	} hpf_mode_t;

	// Power state machine, one-hot
	typedef enum logic [1:0]
	{
		HPF_AWAKE = 2'h1,
		HPF_DOZE  = 2'h2
	} hpf_power_t;

	// One pin seen from inside: level driven and active-low enable
	typedef struct packed
	{
		logic o;
		logic oe_n;
	} hpf_pin_t;

	// A data byte with its handshake
	typedef struct packed
	{
		logic       valid;
		logic [7:0] data;
	} hpf_byte_t;
endpackage : hpf_pkg

//--- hpf_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpf_regs.svh"

// Byte FIFO in flip-flops; depth must be a power of two
module hpf_fifo #(
	parameter int DEPTH = 2,
	parameter int AW    = 1
) (
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [7:0]    in_data,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [7:0]         out_data,
	output logic [AW:0]        level
);
	logic [7:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	// Honest flags straight from the count
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];
	assign level     = cnt_q;

	// Storage writes only
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// Pointers and count; power-of-two depth lets pointers wrap freely
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : hpf_fifo

module hpf_pin_select (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              link_clk,
	input  wire logic [1:0]        if_sel_pin,
	input  wire logic              host_serial_in,
	input  wire logic              host_chip_select,
	input  wire logic              host_tx_bit,
	output hpf_pkg::hpf_pin_t      host_serial_out,
	input  wire logic              echo_disable,
	output logic                   echo_active,
	input  wire logic              doze_request_n,
	output logic                   awake_indicator,
	input  wire logic              flow_pin_i,
	output hpf_pkg::hpf_pin_t      host_flow_permit,
	input  wire logic              mf0_i,
	output hpf_pkg::hpf_pin_t      mf0,
	input  wire logic              mf1_i,
	output hpf_pkg::hpf_pin_t      mf1,
	input  wire logic              pin_func_wr,
	input  wire logic [1:0]        pin_func_wdata,
	output logic [1:0]             pin_func,
	output hpf_pkg::hpf_mode_t     host_mode,
	input  wire logic [7:0]        cfg_channel,
	input  wire logic [1:0]        cfg_rate,
	output logic [7:0]             channel_index,
	output logic [14:0]            carrier_khz,
	output logic [1:0]             rate_code,
	output logic                   tx_gate_open,
	input  wire logic              noise_detected,
	input  wire logic              bus_busy,
	input  wire logic              line_tx_busy,
	output logic                   line_drive_active,
	output hpf_pkg::hpf_byte_t     tx_out,
	input  wire logic              tx_out_ready,
	input  wire hpf_pkg::hpf_byte_t rx_in,
	output logic                   rx_in_ready,
	output hpf_pkg::hpf_byte_t     rx_out,
	input  wire logic              rx_out_ready
);
	localparam int NS = 7;

	logic [NS-1:0]      raw;
	logic [NS-1:0]      s1_q;
	logic [NS-1:0]      s2_q;
	hpf_pkg::hpf_mode_t mode;
	logic               dmx;
	logic               serial;
	logic               doze_n_s;
	logic               echo_s;
	logic               flow_s;
	logic               mf0_s;
	logic               mf1_s;
	logic [1:0]         func_q;
	hpf_pkg::hpf_power_t pwr_q;
	logic [7:0]         lk_shift_q;
	logic [2:0]         lk_cnt_q;
	logic [7:0]         lk_byte_q;
	logic               lk_tog_q;
	logic [2:0]         tog_q;
	logic               cap_valid;
	logic [7:0]         cap_data;
	logic               txf_ready;
	logic               txf_valid;
	logic [7:0]         txf_data;
	logic [10:0]        txf_level;
	logic               gate_mode;
	logic               drain_ok;
	logic               skid_ready;
	logic               skid_valid;
	logic [7:0]         skid_data;
	logic               rxf_valid;
	logic [7:0]         rxf_data;

	// Strap, doze, echo, flow and both function-pin inputs pass two flops before use
	assign raw = {doze_request_n, echo_disable, flow_pin_i, mf1_i, mf0_i,
		if_sel_pin};
	for (genvar i = 0; i < NS; i++)
	begin : g_sync
		always_ff @(posedge clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				s1_q[i] <= 1'b1;
				s2_q[i] <= 1'b1;
			end
			else
			begin
				s1_q[i] <= raw[i];
				s2_q[i] <= s1_q[i];
			end
		end
	end

	// Straps decoded; reset value of the flops reads as I2C
	assign mode     = hpf_pkg::hpf_mode_t'(s2_q[1:0]);
	assign dmx      = (mode == hpf_pkg::HPF_DMX);
	assign serial   = (mode == hpf_pkg::HPF_SPI) || (mode == hpf_pkg::HPF_I2C);
	assign mf0_s    = s2_q[2];
	assign mf1_s    = s2_q[3];
	assign flow_s   = s2_q[4];
	assign echo_s   = s2_q[5];
	assign doze_n_s = s2_q[6];
	assign host_mode = mode;
	assign pin_func  = func_q;

	// Pin-function field; async reset lands on the default code
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			func_q <= `HPF_FUNC_RST;
		else if (pin_func_wr)
			func_q <= pin_func_wdata;
	end

	// Sleep only once the transmit path has emptied, so no frame is cut
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pwr_q <= hpf_pkg::HPF_AWAKE;
		else
		begin
			case (pwr_q)
				hpf_pkg::HPF_AWAKE:
					if (!doze_n_s && !txf_valid && !skid_valid && !line_tx_busy)
						pwr_q <= hpf_pkg::HPF_DOZE;
				hpf_pkg::HPF_DOZE:
					if (doze_n_s)
						pwr_q <= hpf_pkg::HPF_AWAKE;
				default:
					pwr_q <= hpf_pkg::HPF_AWAKE;
			endcase
		end
	end

	// Link side: bytes shift in MSB first while chip select is low.
	// Link clock may stop between frames, so only whole bytes are sent.
	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lk_shift_q <= 8'h00;
			lk_cnt_q   <= 3'h0;
			lk_byte_q  <= 8'h00;
			lk_tog_q   <= 1'b0;
		end
		else if (!host_chip_select)
		begin
			lk_shift_q <= {lk_shift_q[6:0], host_serial_in};
			lk_cnt_q   <= lk_cnt_q + 3'h1;
			if (lk_cnt_q == 3'h7)
			begin
				lk_byte_q <= {lk_shift_q[6:0], host_serial_in};
				lk_tog_q  <= ~lk_tog_q;
			end
		end
	end

	// Toggle crossing; byte stays put for eight link clocks, ample to settle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tog_q <= 3'h0;
		else
			tog_q <= {tog_q[1:0], lk_tog_q};
	end
	assign cap_valid = (tog_q[2] != tog_q[1]) && serial;
	assign cap_data  = lk_byte_q;

	// Transmit FIFO: bytes enter only in SPI and I2C protocols
	hpf_fifo #(
		.DEPTH (`HPF_FIFO_DEPTH),
		.AW    (`HPF_FIFO_AW)
	) u_txf (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (cap_valid),
		.in_ready  (txf_ready),
		.in_data   (cap_data),
		.out_valid (txf_valid),
		.out_ready (skid_ready && drain_ok),
		.out_data  (txf_data),
		.level     (txf_level)
	);

	// Transmit gate holds frames back when its pin role is active
	assign gate_mode = (mode == hpf_pkg::HPF_UART && func_q == `HPF_FUNC_ALT)
		|| (serial && (func_q == `HPF_FUNC_RST || func_q == `HPF_FUNC_ALT));
	assign drain_ok  = (pwr_q == hpf_pkg::HPF_AWAKE) && (!gate_mode || mf0_s);

	// Two-entry buffer before the modem; a modem stall backs up the FIFO
	hpf_fifo #(
		.DEPTH (`HPF_SKID_DEPTH),
		.AW    (`HPF_SKID_AW)
	) u_skid (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (txf_valid && drain_ok),
		.in_ready  (skid_ready),
		.in_data   (txf_data),
		.out_valid (skid_valid),
		.out_ready (tx_out_ready),
		.out_data  (skid_data),
		.level     ()
	);
	assign tx_out.valid = skid_valid;
	assign tx_out.data  = skid_data;

	// Receive FIFO toward the host protocol engine
	hpf_fifo #(
		.DEPTH (`HPF_FIFO_DEPTH),
		.AW    (`HPF_FIFO_AW)
	) u_rxf (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (rx_in.valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_in.data),
		.out_valid (rxf_valid),
		.out_ready (rx_out_ready),
		.out_data  (rxf_data),
		.level     ()
	);
	assign rx_out.valid = rxf_valid;
	assign rx_out.data  = rxf_data;

	// Channel: pins in DMX, else configuration, bad index held; rate: pins in UART code 00, else configuration
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			channel_index <= 8'h00;
			rate_code     <= `HPF_RATE_1M4;
		end
		else
		begin
			if (dmx)
				channel_index <= {5'h00, flow_s, mf1_s, mf0_s};
			else if (cfg_channel < `HPF_CHAN_COUNT)
				channel_index <= cfg_channel;
			if (mode == hpf_pkg::HPF_UART && func_q == `HPF_FUNC_RST)
				rate_code <= {mf1_s, mf0_s};
			else
				rate_code <= cfg_rate;
		end
	end
	assign carrier_khz = `HPF_CHAN_BASE_KHZ
		+ 15'(channel_index * `HPF_CHAN_STEP_KHZ);

	// Pin roles and registered outputs
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mf0              <= '{o: 1'b0, oe_n: 1'b1};
			mf1              <= '{o: 1'b0, oe_n: 1'b1};
			host_flow_permit <= '{o: 1'b0, oe_n: 1'b1};
			host_serial_out  <= '{o: 1'b1, oe_n: 1'b1};
			echo_active      <= 1'b0;
			awake_indicator  <= 1'b1;
			line_drive_active <= 1'b0;
			tx_gate_open     <= 1'b1;
		end
		else
		begin
			// First pin: noise output for code 10 outside DMX
			mf0.o    <= noise_detected;
			mf0.oe_n <= dmx || (func_q != `HPF_FUNC_OUT);
			// Second pin: busy in UART 01 or serial 00
			mf1.o    <= bus_busy;
			mf1.oe_n <= !((mode == hpf_pkg::HPF_UART
				&& func_q == `HPF_FUNC_ALT)
				|| (serial && func_q == `HPF_FUNC_RST));
			// Flow pin is an input in DMX mode
			host_flow_permit.o <= txf_level
				< 11'(`HPF_FIFO_DEPTH) - `HPF_PERMIT_MARGIN;
			host_flow_permit.oe_n <= dmx;
			// Open drain in I2C, push-pull otherwise
			host_serial_out.o    <= (mode == hpf_pkg::HPF_I2C) ? 1'b0
				: host_tx_bit;
			host_serial_out.oe_n <= (mode == hpf_pkg::HPF_I2C)
				? host_tx_bit : 1'b0;
			echo_active       <= (mode == hpf_pkg::HPF_UART) && !echo_s;
			awake_indicator   <= (pwr_q == hpf_pkg::HPF_AWAKE);
			line_drive_active <= line_tx_busy;
			tx_gate_open      <= drain_ok;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	func_default_a: assert property (
		$rose(reset_n) |-> pin_func == `HPF_FUNC_RST)
		else $error("pin function not default after reset");
	permit_level_a: assert property (
		txf_level >= 11'(`HPF_FIFO_DEPTH) - `HPF_PERMIT_MARGIN && !dmx
		|=> !host_flow_permit.o)
		else $error("flow permit high with full transmit fifo");
	awake_sleep_a: assert property (
		pwr_q == hpf_pkg::HPF_DOZE |=> !awake_indicator)
		else $error("awake indication high while dozing");
	doze_exit_a: assert property (
		pwr_q == hpf_pkg::HPF_DOZE && doze_n_s
		|=> pwr_q == hpf_pkg::HPF_AWAKE ##1 awake_indicator)
		else $error("device failed to wake");
	noise_pin_a: assert property (
		!dmx && func_q == `HPF_FUNC_OUT && $stable(func_q)
		|=> !mf0.oe_n && mf0.o == $past(noise_detected))
		else $error("first pin not driving noise flag");
	busy_pin_a: assert property (
		serial && func_q == `HPF_FUNC_RST |=> !mf1.oe_n)
		else $error("second pin not driving busy");
	uart_busy_a: assert property (
		mode == hpf_pkg::HPF_UART && func_q != `HPF_FUNC_ALT
		|=> mf1.oe_n)
		else $error("second pin driven in input role");
	drive_track_a: assert property (
		1'b1 |=> line_drive_active == $past(line_tx_busy))
		else $error("drive active does not track transmission");
	dmx_chan_a: assert property (
		dmx ##1 dmx |-> channel_index == {5'h00, $past(flow_s),
		$past(mf1_s), $past(mf0_s)})
		else $error("channel not taken from pins in dmx mode");
	chan_range_a: assert property (
		channel_index < `HPF_CHAN_COUNT)
		else $error("channel index out of range");
	i2c_od_a: assert property (
		mode == hpf_pkg::HPF_I2C |=> host_serial_out.o == 1'b0)
		else $error("serial out pushes high in i2c mode");
	gate_hold_a: assert property (
		gate_mode && !mf0_s |=> !tx_gate_open)
		else $error("transmit gate open with gate pin low");

	cov_frame_c: cover property (cap_valid ##[1:40] tx_out.valid);
	cov_sleep_c: cover property (
		pwr_q == hpf_pkg::HPF_DOZE ##[1:50] pwr_q == hpf_pkg::HPF_AWAKE);
	cov_stall_c: cover property (tx_out.valid && !tx_out_ready [*4]);
	cov_rx_c: cover property (rx_out.valid && rx_out_ready);
endmodule : hpf_pin_select
`default_nettype wire

//--- hpf_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host controller on the serial link; its clock only runs inside a frame
module hpf_host_model (
	output var logic link_clk,
	output var logic host_chip_select,
	output var logic host_serial_in
);
	// Released lines rest at their pull-up level
	initial
	begin
		link_clk = 1'b0;
		host_chip_select = 1'b1;
		host_serial_in = 1'b1;
	end

	// One byte, MSB first; data moves while the clock is low
	task automatic send_byte(input logic [7:0] b);
		int i;
		#37;
		host_chip_select = 1'b0;
		for (i = 7; i >= 0; i--)
		begin
			host_serial_in = b[i];
			#62.5;
			link_clk = 1'b1;
			#62.5;
			link_clk = 1'b0;
		end
		#62.5;
		host_chip_select = 1'b1;
		host_serial_in = 1'b1;
	endtask : send_byte
endmodule : hpf_host_model

`default_nettype wire

//--- test_hpf_pin_select.sv
`timescale 1ns/1ps
`default_nettype none

module test_hpf_pin_select;
	logic               clk, reset_n, link_clk, host_chip_select;
	logic               host_serial_in, host_tx_bit, echo_disable;
	logic               echo_active, doze_request_n, awake_indicator;
	logic               flow_pin_i, mf0_i, mf1_i, pin_func_wr;
	logic               tx_gate_open, noise_detected, bus_busy;
	logic               line_tx_busy, line_drive_active, tx_out_ready;
	logic               rx_in_ready, rx_out_ready;
	logic [1:0]         if_sel_pin, pin_func_wdata, pin_func;
	logic [1:0]         cfg_rate, rate_code;
	logic [7:0]         cfg_channel, channel_index;
	logic [14:0]        carrier_khz;
	hpf_pkg::hpf_pin_t  host_serial_out, host_flow_permit, mf0, mf1;
	hpf_pkg::hpf_mode_t host_mode;
	hpf_pkg::hpf_byte_t tx_out, rx_in, rx_out;
	int                 err_total, checked;

	hpf_pin_select hpf_pin_select_inst (.clk, .reset_n, .link_clk,
		.if_sel_pin, .host_serial_in, .host_chip_select, .host_tx_bit,
		.host_serial_out, .echo_disable, .echo_active, .doze_request_n,
		.awake_indicator, .flow_pin_i, .host_flow_permit, .mf0_i, .mf0,
		.mf1_i, .mf1, .pin_func_wr, .pin_func_wdata, .pin_func,
		.host_mode, .cfg_channel, .cfg_rate, .channel_index, .carrier_khz,
		.rate_code, .tx_gate_open, .noise_detected, .bus_busy,
		.line_tx_busy, .line_drive_active, .tx_out, .tx_out_ready, .rx_in,
		.rx_in_ready, .rx_out, .rx_out_ready);

	hpf_host_model hpf_host_model_inst (.link_clk, .host_chip_select,
		.host_serial_in);

	// 250 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Compare one value; case equality so unknowns fail
	task automatic chk_v(input string n, input logic [14:0] e, g);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk_v

	task automatic results();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	function automatic logic sig(input int s);
		case (s)
			0: return awake_indicator;
			1: return tx_out.valid;
			default: return rx_out.valid;
		endcase
	endfunction : sig

	// Bounded wait; a hang ends the run as a failure
	task automatic wait_for(input int s, input logic e);
		int k;
		for (k = 0; k < 300; k++)
		begin
			if (sig(s) === e)
				return;
			cyc(1);
		end
		err_total++;
		$display("[ERR] wait %0d exp %b got %b", s, e, sig(s));
		results();
	endtask : wait_for

	// Straps pass two sync flops before they count
	task automatic set_mode(input logic [1:0] m);
		if_sel_pin = m;
		cyc(6);
	endtask : set_mode

	task automatic set_func(input logic [1:0] f);
		pin_func_wr = 1'b1;
		pin_func_wdata = f;
		cyc(1);
		pin_func_wr = 1'b0;
		cyc(5);
	endtask : set_func

	// Every strap code and how the serial out pin is driven in it
	task automatic t_modes();
		int m, b;
		for (m = 0; m < 4; m++)
		begin
			set_mode(m[1:0]);
			chk_v("mode", m, host_mode);
			for (b = 0; b < 2; b++)
			begin
				host_tx_bit = b[0];
				cyc(2);
				chk_v("hso", (m == 3) ? {1'b0, b[0]} : {b[0], 1'b0},
					host_serial_out);
			end
		end
	endtask : t_modes

	task automatic t_uart();
		set_mode(2'h0);
		cyc(5);
		chk_v("echo", 1, echo_active);
		echo_disable = 1'b1;
		cyc(5);
		chk_v("echo", 0, echo_active);
		mf0_i = 1'b1;
		set_func(2'h0);
		chk_v("rate", 2'h1, rate_code);
		chk_v("oe", 2'h3, {mf0.oe_n, mf1.oe_n});
		bus_busy = 1'b1;
		mf0_i = 1'b0;
		set_func(2'h1);
		chk_v("mf1", 2'h2, mf1);
		chk_v("gate", 0, tx_gate_open);
		noise_detected = 1'b1;
		set_func(2'h2);
		chk_v("mf0", 2'h2, mf0);
		set_func(2'h3);
		chk_v("oe", 2'h3, {mf0.oe_n, mf1.oe_n});
	endtask : t_uart

	task automatic t_spi();
		set_mode(2'h2);
		bus_busy = 1'b0;
		mf0_i = 1'b1;
		set_func(2'h0);
		chk_v("mf1", 2'h0, mf1);
		chk_v("gate", 1, tx_gate_open);
		chk_v("permit", 2'h2, host_flow_permit);
		bus_busy = 1'b1;
		mf0_i = 1'b0;
		cyc(5);
		chk_v("mf1", 2'h2, mf1);
		chk_v("gate", 0, tx_gate_open);
		set_func(2'h1);
		chk_v("gate", 0, tx_gate_open);
		set_func(2'h2);
		chk_v("mf0", 2'h2, mf0);
		noise_detected = 1'b0;
		cyc(2);
		chk_v("mf0", 2'h0, mf0);
		set_func(2'h3);
		chk_v("oe", 2'h3, {mf0.oe_n, mf1.oe_n});
	endtask : t_spi

	task automatic t_dmx();
		set_mode(2'h1);
		flow_pin_i = 1'b1;
		mf0_i = 1'b1;
		mf1_i = 1'b0;
		cyc(6);
		chk_v("chan", 8'h05, channel_index);
		chk_v("khz", 15'h157c, carrier_khz);
		chk_v("oe", 3'h7, {host_flow_permit.oe_n, mf0.oe_n, mf1.oe_n});
	endtask : t_dmx

	// Channel range edge and all four rate codes
	task automatic t_chan();
		int r;
		set_mode(2'h2);
		set_func(2'h0);
		cfg_channel = 8'hfa;
		cyc(4);
		chk_v("chan", 8'hfa, channel_index);
		chk_v("khz", 15'h7530, carrier_khz);
		cfg_channel = 8'hfb;
		cyc(4);
		chk_v("chan", 8'hfa, channel_index);
		cfg_channel = 8'h00;
		cyc(4);
		chk_v("khz", 15'h1388, carrier_khz);
		for (r = 0; r < 4; r++)
		begin
			cfg_rate = r[1:0];
			cyc(3);
			chk_v("rate", r, rate_code);
		end
	endtask : t_chan

	task automatic t_drive();
		chk_v("drive", 0, line_drive_active);
		line_tx_busy = 1'b1;
		cyc(1);
		chk_v("drive", 1, line_drive_active);
		cyc(5);
		chk_v("drive", 1, line_drive_active);
		line_tx_busy = 1'b0;
		cyc(1);
		chk_v("drive", 0, line_drive_active);
	endtask : t_drive

	// Modem side stalls, then takes one byte
	task automatic take_tx(input logic [7:0] e);
		wait_for(1, 1'b1);
		cyc(10);
		chk_v("tx", e, tx_out.data);
		tx_out_ready = 1'b1;
		cyc(1);
		tx_out_ready = 1'b0;
	endtask : take_tx

	task automatic t_link();
		mf0_i = 1'b1;
		cyc(5);
		chk_v("permit", 1, host_flow_permit.o);
		hpf_host_model_inst.send_byte(8'ha5);
		take_tx(8'ha5);
		set_mode(2'h3);
		hpf_host_model_inst.send_byte(8'h3c);
		take_tx(8'h3c);
		set_mode(2'h0);
		hpf_host_model_inst.send_byte(8'h11);
		cyc(20);
		chk_v("tx drop", 0, tx_out.valid);
	endtask : t_link

	// Fill the receive path with the reader stalled, then drain in order
	task automatic t_rx();
		int n, j;
		n = 0;
		rx_in.valid = 1'b1;
		rx_in.data = 8'h00;
		while (rx_in_ready === 1'b1 && n < 1100)
		begin
			cyc(1);
			n++;
			rx_in.data = n[7:0];
		end
		rx_in.valid = 1'b0;
		chk_v("rx fill", 15'd1024, n[14:0]);
		for (j = 0; j < n; j++)
		begin
			wait_for(2, 1'b1);
			chk_v("rx", j[7:0], rx_out.data);
			rx_out_ready = 1'b1;
			cyc(1);
			rx_out_ready = 1'b0;
			cyc(1);
		end
		chk_v("rx empty", 0, rx_out.valid);
	endtask : t_rx

	task automatic t_sleep();
		doze_request_n = 1'b0;
		wait_for(0, 1'b0);
		doze_request_n = 1'b1;
		wait_for(0, 1'b1);
	endtask : t_sleep

	// Reset in mid-run brings the field back to its default
	task automatic t_reset();
		set_func(2'h2);
		chk_v("func", 2'h2, pin_func);
		reset_n = 1'b0;
		cyc(2);
		chk_v("func", 2'h0, pin_func);
		chk_v("awake", 1, awake_indicator);
		reset_n = 1'b1;
		cyc(4);
	endtask : t_reset

	// Main sequence
	initial
	begin
		{reset_n, host_tx_bit, echo_disable, flow_pin_i} = 4'h0;
		{mf0_i, mf1_i, pin_func_wr, noise_detected, bus_busy} = 5'h00;
		{line_tx_busy, tx_out_ready, rx_out_ready} = 3'h0;
		doze_request_n = 1'b1;
		if_sel_pin = 2'h0;
		pin_func_wdata = 2'h0;
		cfg_channel = 8'h00;
		cfg_rate = 2'h0;
		rx_in = '0;
		err_total = 0;
		checked = 0;
		cyc(16);
		chk_v("func", 2'h0, pin_func);
		reset_n = 1'b1;
		cyc(4);
		t_modes();
		t_uart();
		t_spi();
		t_dmx();
		t_chan();
		t_drive();
		t_link();
		t_rx();
		t_sleep();
		t_reset();
		results();
	end
endmodule : test_hpf_pin_select

`default_nettype wire
